//--- core/ddc_pkg.sv
// Constants shared by the down-converter back end.
package ddc_pkg;
  localparam int SAMPLE_W = 14;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int NUM_DDC = 2;
  localparam int NUM_STAGES = 4;
  localparam int NUM_REGS = 14;
  localparam int IDX_STRIDE = 6;
  localparam int WORD_W = 3 + 4 * DATA_W;

  localparam logic [11:0] ADDR_MODE = 12'h200;
  localparam logic [11:0] ADDR_DECIM = 12'h201;
  localparam logic [11:0] ADDR_CTRL0 = 12'h310;
  localparam logic [11:0] ADDR_ROUTE0 = 12'h311;
  localparam logic [11:0] ADDR_FTW0_A = 12'h314;
  localparam logic [11:0] ADDR_FTW0_B = 12'h315;
  localparam logic [11:0] ADDR_POW0_A = 12'h320;
  localparam logic [11:0] ADDR_POW0_B = 12'h321;
  localparam logic [11:0] ADDR_CTRL1 = 12'h330;
  localparam logic [11:0] ADDR_ROUTE1 = 12'h331;
  localparam logic [11:0] ADDR_FTW1_A = 12'h334;
  localparam logic [11:0] ADDR_FTW1_B = 12'h335;
  localparam logic [11:0] ADDR_POW1_A = 12'h340;
  localparam logic [11:0] ADDR_POW1_B = 12'h341;

  // Storage slots; channel 1 sits IDX_STRIDE above channel 0.
  localparam int IDX_MODE = 0;
  localparam int IDX_DECIM = 1;
  localparam int IDX_CTRL = 2;
  localparam int IDX_ROUTE = 3;
  localparam int IDX_FTW_A = 4;
  localparam int IDX_FTW_B = 5;
  localparam int IDX_POW_A = 6;
  localparam int IDX_POW_B = 7;
  localparam logic [3:0] IDX_NONE = 4'hf;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MODE_ONE_IQ = 8'h01;
  localparam logic [7:0] MODE_TWO_IQ = 8'h02;
  localparam logic [7:0] MODE_TWO_I = 8'h22;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [3:0] COUNT_TWO = 4'h2;
  localparam int MODE_COUNT_MSB = 3;
  localparam int MODE_IONLY_BIT = 5;
  localparam int CTRL_CMIX_BIT = 7;
  localparam int CTRL_GAIN_BIT = 6;
  localparam int CTRL_C2R_BIT = 3;
  localparam int CTRL_FILT_MSB = 1;
  localparam int DECIM_MSB = 2;
  localparam int ROUTE_I_BIT = 0;
  localparam int ROUTE_Q_BIT = 2;
  localparam logic [1:0] FILT_TWO = 2'h0;
  localparam logic [1:0] FILT_THREE = 2'h1;
  localparam logic [1:0] FILT_FOUR = 2'h2;
  localparam logic [1:0] FILT_FINAL = 2'h3;
  localparam logic [15:0] DATA_MAX = 16'h7fff;
  localparam logic [15:0] DATA_MIN = 16'h8000;
endpackage : ddc_pkg

//--- core/ddc_c2r_core.sv
// Down-converter back end: settings, mixers, half-band chains and real conversion.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each channel has its own control byte and its own real-conversion stage.
// - Real conversion runs the final half-band stage then an fs/4 up-mixer.
// - After the up-mix only the in-phase part leaves; quadrature is zeroed.
// - With real conversion on, the final stage keeps its rate.
// - Mode byte 0x01 gives one channel with I and Q.
// - Mode byte 0x02 gives two channels with I and Q.
// - Mode byte 0x22 gives two channels with I only.
// - Chip decimation byte 0x01 means two, 0x02 means four.
// - Control 0x83: complex mixer, no gain, complex out, final stage only.
// - Control 0x80: complex mixer, no gain, complex out, last two stages.
// - Control 0x89: complex mixer, no gain, real out, last three stages.
// - Routing byte 0x04 takes I from converter A and Q from B.
// - Channel 1 bytes sit at 0x330 and 0x331 with channel 0 encodings.
module ddc_c2r_core (
  // Clock, reset, freeze
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Converter samples
  input  wire logic [13:0] sample_a,
  input  wire logic [13:0] sample_b,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  // Output toward the framer
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [1:0]  out_lanes,
  output logic             out_q_used,
  output logic      [15:0] out_i0,
  output logic      [15:0] out_q0,
  output logic      [15:0] out_i1,
  output logic      [15:0] out_q1,
  output logic             config_mismatch
);

  function automatic logic [3:0] reg_index(input logic [11:0] a);
    unique case (a)
      ddc_pkg::ADDR_MODE:   reg_index = 4'h0;
      ddc_pkg::ADDR_DECIM:  reg_index = 4'h1;
      ddc_pkg::ADDR_CTRL0:  reg_index = 4'h2;
      ddc_pkg::ADDR_ROUTE0: reg_index = 4'h3;
      ddc_pkg::ADDR_FTW0_A: reg_index = 4'h4;
      ddc_pkg::ADDR_FTW0_B: reg_index = 4'h5;
      ddc_pkg::ADDR_POW0_A: reg_index = 4'h6;
      ddc_pkg::ADDR_POW0_B: reg_index = 4'h7;
      ddc_pkg::ADDR_CTRL1:  reg_index = 4'h8;
      ddc_pkg::ADDR_ROUTE1: reg_index = 4'h9;
      ddc_pkg::ADDR_FTW1_A: reg_index = 4'ha;
      ddc_pkg::ADDR_FTW1_B: reg_index = 4'hb;
      ddc_pkg::ADDR_POW1_A: reg_index = 4'hc;
      ddc_pkg::ADDR_POW1_B: reg_index = 4'hd;
      default:              reg_index = ddc_pkg::IDX_NONE;
    endcase
  endfunction : reg_index

  function automatic logic [3:0] chan_idx(input int c, input int base);
    return 4'(base + c * ddc_pkg::IDX_STRIDE);
  endfunction : chan_idx

  function automatic logic [2:0] stages_used(input logic [1:0] code);
    unique case (code)
      ddc_pkg::FILT_FINAL: stages_used = 3'h1;
      ddc_pkg::FILT_TWO:   stages_used = 3'h2;
      ddc_pkg::FILT_THREE: stages_used = 3'h3;
      ddc_pkg::FILT_FOUR:  stages_used = 3'h4;
    endcase
  endfunction : stages_used

  function automatic logic signed [15:0] widen(input logic [13:0] x);
    return 16'(signed'(x));
  endfunction : widen

  // Saturating negate, so the most negative code does not wrap.
  function automatic logic signed [15:0] neg(input logic signed [15:0] x);
    return (x == ddc_pkg::DATA_MIN) ? ddc_pkg::DATA_MAX : -x;
  endfunction : neg

  // Multiplies i + jq by exp(-j*k*pi/2); returns {i, q}.
  function automatic logic [31:0] rotate(input logic signed [15:0] i,
                                         input logic signed [15:0] q,
                                         input logic [1:0] k);
    unique case (k)
      2'h0: rotate = {i, q};
      2'h1: rotate = {q, neg(i)};
      2'h2: rotate = {neg(i), neg(q)};
      2'h3: rotate = {neg(q), i};
    endcase
  endfunction : rotate

  // Short 1-2-1 half-band kernel; unity gain at DC.
  function automatic logic signed [15:0] halfband(input logic signed [15:0] a,
                                                  input logic signed [15:0] b,
                                                  input logic signed [15:0] c);
    logic signed [17:0] s;
    s = 18'(a) + 18'(b) + 18'(b) + 18'(c);
    return 16'(s >>> 2);
  endfunction : halfband

  function automatic logic signed [15:0] dbl(input logic signed [15:0] x);
    if (x[ddc_pkg::DATA_W-1] != x[ddc_pkg::DATA_W-2])
      return x[ddc_pkg::DATA_W-1] ? ddc_pkg::DATA_MIN : ddc_pkg::DATA_MAX;
    return {x[ddc_pkg::DATA_W-2:0], 1'b0};
  endfunction : dbl

  // Settings storage.
  logic [7:0] cfg [ddc_pkg::NUM_REGS];
  wire [3:0] reg_idx = reg_index(reg_addr);
  wire reg_hit = reg_idx != ddc_pkg::IDX_NONE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int k = 0; k < ddc_pkg::NUM_REGS; k++) begin
        cfg[k] <= ddc_pkg::RESET_BYTE;
      end
      reg_rdata <= ddc_pkg::RESET_BYTE;
    end else if (clk_en) begin
      if (reg_write && reg_hit) begin
        cfg[reg_idx] <= reg_wdata;
      end
      if (reg_read) begin
        reg_rdata <= reg_hit ? cfg[reg_idx] : ddc_pkg::RESET_BYTE;
      end
    end
  end

  // Chip-level mode decode.
  wire [7:0] mode = cfg[ddc_pkg::IDX_MODE];
  wire [3:0] ddc_count = mode[ddc_pkg::MODE_COUNT_MSB:0];
  wire i_only = mode[ddc_pkg::MODE_IONLY_BIT];
  wire both_on = ddc_count == ddc_pkg::COUNT_TWO;
  wire bypass_all = !both_on && ddc_count != ddc_pkg::COUNT_ONE;
  wire [1:0] lane_on = {both_on, !bypass_all};
  wire [7:0] decim_byte = cfg[ddc_pkg::IDX_DECIM];
  wire [2:0] chip_log2 = decim_byte[ddc_pkg::DECIM_MSB:0];

  wire step = clk_en && sample_valid && sample_ready;
  logic pend;
  logic [13:0] raw_a;
  logic [13:0] raw_b;

  wire signed [15:0] lane_i [ddc_pkg::NUM_DDC];
  wire signed [15:0] lane_q [ddc_pkg::NUM_DDC];
  wire [1:0] lane_v;
  wire [1:0] lane_bad;

  for (genvar c = 0; c < ddc_pkg::NUM_DDC; c++) begin : g_ddc
    wire [7:0] ctrl = cfg[chan_idx(c, ddc_pkg::IDX_CTRL)];
    wire [7:0] route = cfg[chan_idx(c, ddc_pkg::IDX_ROUTE)];
    wire [15:0] frequency_tuning_word = {cfg[chan_idx(c, ddc_pkg::IDX_FTW_B)],
                       cfg[chan_idx(c, ddc_pkg::IDX_FTW_A)]};
    wire [15:0] phase_offset_word = {cfg[chan_idx(c, ddc_pkg::IDX_POW_B)],
                       cfg[chan_idx(c, ddc_pkg::IDX_POW_A)]};
    wire cmix = ctrl[ddc_pkg::CTRL_CMIX_BIT];
    wire gain = ctrl[ddc_pkg::CTRL_GAIN_BIT];
    wire c2r_on = ctrl[ddc_pkg::CTRL_C2R_BIT];
    wire [2:0] n_st = stages_used(ctrl[ddc_pkg::CTRL_FILT_MSB:0]);

    // A real mixer treats the input as real, so quadrature enters as zero.
    wire signed [15:0] src_i = widen(route[ddc_pkg::ROUTE_I_BIT] ? sample_b : sample_a);
    wire signed [15:0] src_q = cmix ?
        widen(route[ddc_pkg::ROUTE_Q_BIT] ? sample_b : sample_a) : '0;

    // Quadrant-only oscillator: coarse, but costs no sine table.
    logic [15:0] nco_acc;
    wire [15:0] nco_ph = nco_acc + phase_offset_word;
    wire [31:0] mixed = rotate(src_i, src_q, nco_ph[ddc_pkg::DATA_W-1 -: 2]);
    wire signed [15:0] g_i = gain ? dbl(mixed[31:16]) : mixed[31:16];
    wire signed [15:0] g_q = gain ? dbl(mixed[15:0]) : mixed[15:0];

    logic signed [15:0] si [ddc_pkg::NUM_STAGES];
    logic signed [15:0] sq [ddc_pkg::NUM_STAGES];
    logic signed [15:0] d1i [ddc_pkg::NUM_STAGES];
    logic signed [15:0] d2i [ddc_pkg::NUM_STAGES];
    logic signed [15:0] d1q [ddc_pkg::NUM_STAGES];
    logic signed [15:0] d2q [ddc_pkg::NUM_STAGES];
    logic [3:0] sv;
    logic [3:0] ph;
    logic signed [15:0] xi [ddc_pkg::NUM_STAGES];
    logic signed [15:0] xq [ddc_pkg::NUM_STAGES];
    logic [3:0] xv;
    logic [3:0] en;
    logic [1:0] rc;

    always_comb begin
      xi[0] = g_i;
      xq[0] = g_q;
      xv[0] = 1'b1;
      for (int s = 1; s < ddc_pkg::NUM_STAGES; s++) begin
        xi[s] = si[s-1];
        xq[s] = sq[s-1];
        xv[s] = sv[s-1];
      end
      for (int s = 0; s < ddc_pkg::NUM_STAGES; s++) begin
        en[s] = 3'(ddc_pkg::NUM_STAGES - s) <= n_st;
      end
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        nco_acc <= '0;
        sv <= '0;
        ph <= '0;
        for (int s = 0; s < ddc_pkg::NUM_STAGES; s++) begin
          si[s] <= '0;
          sq[s] <= '0;
          d1i[s] <= '0;
          d2i[s] <= '0;
          d1q[s] <= '0;
          d2q[s] <= '0;
        end
      end else if (step) begin
        nco_acc <= nco_acc + frequency_tuning_word;
        for (int s = 0; s < ddc_pkg::NUM_STAGES; s++) begin
          if (!en[s]) begin
            si[s] <= xi[s];
            sq[s] <= xq[s];
            sv[s] <= xv[s];
          end else begin
            // The last stage keeps full rate under real conversion.
            sv[s] <= xv[s] && (ph[s] ||
                     (s == ddc_pkg::NUM_STAGES - 1 && c2r_on));
            if (xv[s]) begin
              d1i[s] <= xi[s];
              d2i[s] <= d1i[s];
              d1q[s] <= xq[s];
              d2q[s] <= d1q[s];
              ph[s] <= !ph[s];
              si[s] <= halfband(xi[s], d1i[s], d2i[s]);
              sq[s] <= halfband(xq[s], d1q[s], d2q[s]);
            end
          end
        end
      end
    end

    // The quarter-turn count moves once per word this channel pushes under real conversion, even when a sample lands too.
    always_ff @(posedge mclk) begin
      if (reset) begin
        rc <= '0;
      end else if (clk_en && pend && lane_v[c] && c2r_on) begin
        rc <= rc + 2'h1;
      end
    end

    // Up-mix by fs/4 is a rotation by -rc quarter turns.
    wire [31:0] up = rotate(si[3], sq[3], 2'(2'h0 - rc));
    assign lane_i[c] = c2r_on ? up[31:16] : si[3];
    assign lane_q[c] = (c2r_on || i_only) ? '0 : sq[3];
    assign lane_v[c] = sv[3] && lane_on[c];
    assign lane_bad[c] = lane_on[c] && (n_st - 3'(c2r_on)) != chip_log2;

    a_real_rate: assert property (
      @(posedge mclk) disable iff (reset)
      step && c2r_on && xv[3] |=> sv[3])
      else $error("final stage decimated under real conversion");
    a_upmix_turns: assert property (
      @(posedge mclk) disable iff (reset)
      clk_en && pend && lane_v[c] && c2r_on |=> rc == $past(rc) + 2'h1)
      else $error("fs/4 up-mixer did not advance");
    a_quad_dropped: assert property (
      @(posedge mclk) disable iff (reset)
      clk_en && pend && lane_v[c] && c2r_on && !out_valid
      |=> out_valid && out_lanes[c] && (c ? out_q1 : out_q0) == '0)
      else $error("quadrature left a real-output channel");
    a_route_ab: assert property (
      @(posedge mclk) disable iff (reset)
      route == 8'h04 && cmix |-> src_i == widen(sample_a) && src_q == widen(sample_b))
      else $error("routing 0x04 did not take I from A and Q from B");
  end

  // Output word and two-entry buffer; head is the output register.
  logic [ddc_pkg::WORD_W-1:0] head;
  logic [ddc_pkg::WORD_W-1:0] tail;
  logic tail_v;
  wire [1:0] push_lanes = bypass_all ? 2'h1 : lane_v;
  wire push = clk_en && pend && (|push_lanes);
  wire [ddc_pkg::WORD_W-1:0] word = bypass_all ?
      {2'h1, 1'b1, widen(raw_a), widen(raw_b), 32'h0} :
      {push_lanes, !i_only, lane_i[0], lane_q[0], lane_i[1], lane_q[1]};
  wire head_free = !out_valid || out_ready;
  wire next_head_v = head_free ? (tail_v || push) : 1'b1;
  wire next_tail_v = head_free ? (tail_v && push) : (tail_v || push);
  // Ready counts the result still in flight so a stall never drops a word.
  wire next_ready = !next_tail_v && !(next_head_v && step);

  assign {out_lanes, out_q_used, out_i0, out_q0, out_i1, out_q1} = head;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pend <= 1'b0;
      raw_a <= '0;
      raw_b <= '0;
      head <= '0;
      tail <= '0;
      tail_v <= 1'b0;
      out_valid <= 1'b0;
      sample_ready <= 1'b0;
      config_mismatch <= 1'b0;
    end else if (clk_en) begin
      pend <= step;
      if (step) begin
        raw_a <= sample_a;
        raw_b <= sample_b;
      end
      if (head_free) begin
        head <= tail_v ? tail : word;
      end
      if (push && (!head_free || tail_v)) begin
        tail <= word;
      end
      out_valid <= next_head_v;
      tail_v <= next_tail_v;
      sample_ready <= next_ready;
      config_mismatch <= |lane_bad;
    end
  end

  a_ctrl_isolation: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && reg_write && reg_addr == ddc_pkg::ADDR_CTRL1
    |=> $stable(cfg[ddc_pkg::IDX_CTRL]))
    else $error("channel 1 control write disturbed channel 0");
  a_second_route: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && reg_write && reg_addr == ddc_pkg::ADDR_ROUTE1
    |=> cfg[ddc_pkg::IDX_ROUTE + ddc_pkg::IDX_STRIDE] == $past(reg_wdata))
    else $error("channel 1 routing byte not stored");
  a_one_ddc_iq: assert property (
    @(posedge mclk) disable iff (reset)
    push && !out_valid && mode == ddc_pkg::MODE_ONE_IQ
    |=> out_valid && out_lanes == 2'h1 && out_q_used)
    else $error("mode 0x01 did not give one I/Q channel");
  a_two_ddc_iq: assert property (
    @(posedge mclk) disable iff (reset)
    push && !out_valid && mode == ddc_pkg::MODE_TWO_IQ && lane_v == 2'h3
    |=> out_valid && out_lanes == 2'h3 && out_q_used)
    else $error("mode 0x02 did not give two I/Q channels");
  a_two_ddc_i: assert property (
    @(posedge mclk) disable iff (reset)
    push && !out_valid && mode == ddc_pkg::MODE_TWO_I
    |=> !out_q_used && out_q0 == '0 && out_q1 == '0)
    else $error("mode 0x22 let quadrature through");
  a_decim_check: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && decim_byte == 8'h02 && lane_on[0] && g_ddc[0].ctrl == 8'h83
    |=> config_mismatch)
    else $error("ratio two against chip ratio four not flagged");
  a_buffer_stall: assert property (
    @(posedge mclk) disable iff (reset)
    out_valid && tail_v && !out_ready |-> !sample_ready ##1 !sample_ready)
    else $error("input taken while buffer full");

endmodule : ddc_c2r_core
`default_nettype wire

//--- tb/ddc_far_side.sv
// Converter sample source and framer sink facing the down-converter back end.
`timescale 1ns/1ps
`default_nettype none
module ddc_far_side (
  // Clock and freeze
  input  wire logic        mclk,
  input  wire logic        clk_en,
  // Bench control
  input  wire logic [13:0] src_a,
  input  wire logic [13:0] src_b,
  input  var  int          target,
  input  wire logic        stall,
  // Converter side
  output logic      [13:0] sample_a,
  output logic      [13:0] sample_b,
  output logic             sample_valid,
  input  wire logic        sample_ready,
  // Framer side
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [66:0] out_word
);
  int          taken;
  logic [66:0] words[$];

  initial begin
    taken = 0;
    sample_a = 14'h0000;
    sample_b = 14'h0000;
    sample_valid = 1'b0;
    out_ready = 1'b0;
  end

  always @(posedge mclk) begin
    if (clk_en && sample_valid && sample_ready) taken <= taken + 1;
    if (clk_en && out_valid && out_ready) words.push_back(out_word);
  end

  // Idle lines toggle every cycle so a stale sample is never mistaken for a held one.
  always @(negedge mclk) begin
    out_ready <= !stall;
    if (taken < target) begin
      sample_valid <= 1'b1;
      sample_a <= src_a;
      sample_b <= src_b;
    end else begin
      sample_valid <= 1'b0;
      sample_a <= ~sample_a;
      sample_b <= ~sample_b;
    end
  end
endmodule : ddc_far_side
`default_nettype wire

//--- tb/ddc_c2r_core_bench.sv
// Self-checking bench for the down-converter back end.
`timescale 1ns/1ps
`default_nettype none
module ddc_c2r_core_bench;
  logic        mclk, reset, clk_en, reg_write, reg_read, stall;
  logic        sample_valid, sample_ready, out_valid, out_ready, out_q_used, config_mismatch;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [13:0] sample_a, sample_b, src_a, src_b;
  logic [1:0]  out_lanes;
  logic [15:0] out_i0, out_q0, out_i1, out_q1;
  logic [66:0] word_bus;
  int          target, error_cnt, cmp_count;
  logic [11:0] addrs[14] = '{ddc_pkg::ADDR_MODE, ddc_pkg::ADDR_DECIM, ddc_pkg::ADDR_CTRL0,
    ddc_pkg::ADDR_ROUTE0, ddc_pkg::ADDR_FTW0_A, ddc_pkg::ADDR_FTW0_B, ddc_pkg::ADDR_POW0_A,
    ddc_pkg::ADDR_POW0_B, ddc_pkg::ADDR_CTRL1, ddc_pkg::ADDR_ROUTE1, ddc_pkg::ADDR_FTW1_A,
    ddc_pkg::ADDR_FTW1_B, ddc_pkg::ADDR_POW1_A, ddc_pkg::ADDR_POW1_B};

  assign word_bus = {out_lanes, out_q_used, out_i0, out_q0, out_i1, out_q1};

  ddc_c2r_core DUT (.mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_lanes(out_lanes), .out_q_used(out_q_used), .out_i0(out_i0), .out_q0(out_q0),
    .out_i1(out_i1), .out_q1(out_q1), .config_mismatch(config_mismatch));

  ddc_far_side far (.mclk(mclk), .clk_en(clk_en), .src_a(src_a), .src_b(src_b),
    .target(target), .stall(stall), .sample_a(sample_a), .sample_b(sample_b),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(word_bus));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [66:0] got, input logic [66:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic fail_wait();
    error_cnt++;
    wrap_up();
  endtask : fail_wait

  task automatic do_reset();
    reset = 1'b1;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    far.words.delete();
    @(negedge mclk);
  endtask : do_reset

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge mclk);
    reg_write = 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge mclk);
    reg_read = 1'b0;
    d = reg_rdata;
    @(negedge mclk);
  endtask : rd

  // Settings go in before any sample, since mixed settings give undefined data.
  task automatic cfg(input logic [7:0] m, dc, c0, c1);
    wr(ddc_pkg::ADDR_MODE, m);
    wr(ddc_pkg::ADDR_DECIM, dc);
    wr(ddc_pkg::ADDR_CTRL0, c0);
    wr(ddc_pkg::ADDR_CTRL1, c1);
    wr(ddc_pkg::ADDR_ROUTE0, 8'h04);
    wr(ddc_pkg::ADDR_ROUTE1, 8'h04);
  endtask : cfg

  // Waits until every requested sample is taken and the output has stayed empty a while.
  task automatic drain();
    int idle;
    idle = 0;
    for (int i = 0; i < 3000 && idle < 8; i++) begin
      @(negedge mclk);
      if (far.taken >= target && out_valid === 1'b0) idle++;
      else idle = 0;
    end
    if (idle < 8) fail_wait();
  endtask : drain

  task automatic feed(input int n);
    target = target + n;
    drain();
  endtask : feed

  task automatic t_regs();
    logic [7:0] d;
    do_reset();
    for (int i = 0; i < 14; i++) begin
      rd(addrs[i], d);
      check(d, 8'h00);
      wr(addrs[i], 8'h30 + 8'(i));
    end
    for (int i = 0; i < 14; i++) begin
      rd(addrs[i], d);
      check(d, 8'h30 + 8'(i));
    end
    wr(12'h202, 8'h77);
    rd(12'h202, d);
    check(d, 8'h00);
    clk_en = 1'b0;
    wr(ddc_pkg::ADDR_MODE, 8'h5a);
    clk_en = 1'b1;
    rd(ddc_pkg::ADDR_MODE, d);
    check(d, 8'h30);
  endtask : t_regs

  // Bypass mode with the framer stalled: the buffer fills, holds its word, then drains whole.
  task automatic t_stall();
    logic [66:0] held;
    int          i;
    do_reset();
    stall = 1'b1;
    target = target + 8;
    for (i = 0; i < 60 && sample_ready !== 1'b0; i++) @(negedge mclk);
    if (i == 60) fail_wait();
    held = word_bus;
    check(out_valid, 1'b1);
    repeat (6) @(negedge mclk);
    check(word_bus, held);
    check(sample_ready, 1'b0);
    stall = 1'b0;
    drain();
    check(far.words.size(), 8);
    for (int k = 0; k < far.words.size(); k++) check(far.words[k][66:65], 2'b01);
  endtask : t_stall

  task automatic t_mode(input logic [7:0] m, dc, c, input int n, nw,
                        input logic [1:0] ln, input logic q);
    do_reset();
    cfg(m, dc, c, c);
    feed(n);
    check(far.words.size(), nw);
    for (int k = 0; k < far.words.size(); k++) begin
      check(far.words[k][66:64], {ln, q});
      if (!q) check({far.words[k][47:32], far.words[k][15:0]}, 32'h0);
    end
    check(config_mismatch, 1'b0);
  endtask : t_mode

  // A steady input up-mixed by a quarter-rate carrier reads x, 0, -x, 0 on the real lane.
  task automatic t_c2r_wave();
    logic [15:0] w[4];
    for (int k = 0; k < 4; k++) w[k] = far.words[far.words.size() - 4 + k][63:48];
    check(w[2], 16'(16'h0000 - w[0]));
    check(w[3], 16'(16'h0000 - w[1]));
    check((w[0] == 16'h0000) ^ (w[1] == 16'h0000), 1'b1);
  endtask : t_c2r_wave

  task automatic t_indep();
    logic [66:0] w;
    do_reset();
    src_b = 14'h0080;
    cfg(8'h02, 8'h02, 8'h89, 8'h80);
    feed(32);
    w = far.words[far.words.size() - 1];
    check(w[66:64], 3'b111);
    check(w[47:32], 16'h0000);
    check(w[15:0], 16'h0080);
    check(w[31:16], 16'h0100);
    src_b = 14'h0000;
  endtask : t_indep

  task automatic t_mismatch();
    wr(ddc_pkg::ADDR_DECIM, 8'h01);
    repeat (3) @(negedge mclk);
    check(config_mismatch, 1'b1);
    wr(ddc_pkg::ADDR_DECIM, 8'h02);
    repeat (3) @(negedge mclk);
    check(config_mismatch, 1'b0);
    wr(ddc_pkg::ADDR_CTRL0, 8'h83);
    repeat (3) @(negedge mclk);
    check(config_mismatch, 1'b1);
  endtask : t_mismatch

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    target = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    stall = 1'b0;
    src_a = 14'h0100;
    src_b = 14'h0000;
    t_regs();
    t_stall();
    // Stage registers move only on taken samples, so the last few stay inside when the
    // source stops and each count falls short of the sample count over the ratio.
    t_mode(8'h01, 8'h01, 8'h83, 16, 6, 2'b01, 1'b1);
    t_mode(8'h02, 8'h02, 8'h80, 16, 3, 2'b11, 1'b1);
    t_mode(8'h22, 8'h02, 8'h89, 48, 11, 2'b11, 1'b0);
    t_c2r_wave();
    t_indep();
    t_mismatch();
    wrap_up();
  end
endmodule : ddc_c2r_core_bench
`default_nettype wire
